// >>> uem_bank.v
// Uncorrectable error suppress bank of one switch port, with status, header log,
// first error pointer and interrupt. APB slave, zero wait states.
// Assumes error events are one-cycle pulses synchronous to pclk, each with its header.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
`include "uem_map.vh"

module uem_bank #(
	parameter ADDR_W = 12
) (
	// Clock and resets
	input wire pclk,
	input wire presetn,
	input wire hot_rst,
	// APB slave
	input wire [ADDR_W-1:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Error events with captured packet header
	input wire [31:0] err_evt,
	input wire [127:0] err_hdr,
	// Logging and message requests
	output reg log_pulse,
	output reg msg_pulse,
	output reg [31:0] msg_vec,
	// Interrupt
	output wire irq
);

	wire [31:0] impl;
	wire [31:0] sup;
	wire [31:0] sts;
	wire [31:0] ien;
	wire [31:0] fwd;
	wire [31:0] bmask;
	wire [31:0] wmask;
	wire setup;
	wire wr_en;
	wire hit_sts;
	wire hit_sup;
	wire hit_ien;
	wire mapped;
	wire any_fwd;
	wire capture;
	reg [31:0] rd_nxt;
	reg [31:0] hdr_r [0:`UEM_HDR_DW-1];
	reg hdr_full_r;
	reg [`UEM_FEP_W-1:0] fep_r;
	reg [`UEM_FEP_W-1:0] fep_nxt;
	integer k;

	// Implemented error positions; all others read zero and drop writes
	assign impl[`UEM_B_TRAIN] = 1'b1;
	assign impl[`UEM_B_TRAIN+3:`UEM_B_TRAIN+1] = 3'h0;
	assign impl[`UEM_B_DLPE] = 1'b1;
	assign impl[`UEM_B_POIS-1:`UEM_B_DLPE+1] = 7'h00;
	assign impl[`UEM_B_POIS] = 1'b1;
	assign impl[`UEM_B_FCPE] = 1'b1;
	assign impl[`UEM_B_CTO] = 1'b1;
	assign impl[`UEM_B_CABT] = 1'b1;
	assign impl[`UEM_B_UCPL] = 1'b1;
	assign impl[`UEM_B_ROVF] = 1'b1;
	assign impl[`UEM_B_MALF] = 1'b1;
	assign impl[`UEM_B_ECRC] = 1'b1;
	assign impl[`UEM_B_UREQ] = 1'b1;
	assign impl[`UEM_B_ACSV] = 1'b1;
	assign impl[31:`UEM_B_ACSV+1] = 10'h000;

	// APB decode
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pwrite;
	assign hit_sts = (paddr == `UEM_OFF_STS);
	assign hit_sup = (paddr == `UEM_OFF_SUP);
	assign hit_ien = (paddr == `UEM_OFF_IEN);
	assign mapped = hit_sts | hit_sup | hit_ien | (paddr == `UEM_OFF_FEP) |
		(paddr == `UEM_OFF_HDR0) | (paddr == `UEM_OFF_HDR1) |
		(paddr == `UEM_OFF_HDR2) | (paddr == `UEM_OFF_HDR3);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign bmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	assign wmask = bmask & impl;

	genvar g;
	generate
		for (g = 0; g < 32; g = g + 1) begin : bit_g
			if (g == `UEM_B_TRAIN || g == `UEM_B_DLPE ||
				(g >= `UEM_B_POIS && g <= `UEM_B_ACSV)) begin : impl_g
				uem_err_slice u_slice (
					.pclk(pclk),
					.presetn(presetn),
					.hot_rst(hot_rst),
					.evt(err_evt[g]),
					.sup_we(wr_en & hit_sup & wmask[g]),
					.sup_d(pwdata[g]),
					.sts_w1c(wr_en & hit_sts & wmask[g] & pwdata[g]),
					.ien_we(wr_en & hit_ien & wmask[g]),
					.ien_d(pwdata[g]),
					.sup_r(sup[g]),
					.sts_r(sts[g]),
					.ien_r(ien[g]),
					.fwd(fwd[g])
				);
			end else begin : rsvd_g
				assign sup[g] = 1'b0;
				assign sts[g] = 1'b0;
				assign ien[g] = 1'b0;
				assign fwd[g] = 1'b0;
			end
		end
	endgenerate

	assign irq = |(sts & ien);

	// Only unsuppressed events reach the header log and the message path
	assign any_fwd = |fwd;
	assign capture = any_fwd & ~hdr_full_r;

	// Lowest unsuppressed event position names the logged error
	always @* begin
		fep_nxt = `UEM_FEP_RST;
		for (k = 31; k >= 0; k = k - 1) begin
			if (fwd[k])
				fep_nxt = k[`UEM_FEP_W-1:0];
		end
	end

	// Header log: four double words, held until the logged status bit is cleared
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hdr_r[0] <= `UEM_ZERO32;
			hdr_r[1] <= `UEM_ZERO32;
			hdr_r[2] <= `UEM_ZERO32;
			hdr_r[3] <= `UEM_ZERO32;
			hdr_full_r <= 1'b0;
			fep_r <= `UEM_FEP_RST;
		end else if (capture) begin
			hdr_r[0] <= err_hdr[31:0];
			hdr_r[1] <= err_hdr[63:32];
			hdr_r[2] <= err_hdr[95:64];
			hdr_r[3] <= err_hdr[127:96];
			hdr_full_r <= 1'b1;
			fep_r <= fep_nxt;
		end else if (hdr_full_r && !sts[fep_r]) begin
			hdr_full_r <= 1'b0;
		end
	end

	// Message requests carry the unsuppressed events of the cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			log_pulse <= 1'b0;
			msg_pulse <= 1'b0;
			msg_vec <= `UEM_ZERO32;
		end else if (hot_rst) begin
			log_pulse <= 1'b0;
			msg_pulse <= 1'b0;
			msg_vec <= `UEM_ZERO32;
		end else begin
			log_pulse <= capture;
			msg_pulse <= any_fwd;
			msg_vec <= fwd;
		end
	end

	// Read data, sampled in the setup cycle
	always @* begin
		case (paddr)
			`UEM_OFF_STS: rd_nxt = sts;
			`UEM_OFF_SUP: rd_nxt = sup;
			`UEM_OFF_FEP: rd_nxt = {27'h0000000, fep_r};
			`UEM_OFF_HDR0: rd_nxt = hdr_r[0];
			`UEM_OFF_HDR1: rd_nxt = hdr_r[1];
			`UEM_OFF_HDR2: rd_nxt = hdr_r[2];
			`UEM_OFF_HDR3: rd_nxt = hdr_r[`UEM_HDR_LAST];
			`UEM_OFF_IEN: rd_nxt = ien;
			default: rd_nxt = `UEM_ZERO32;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= `UEM_ZERO32;
		else if (setup)
			prdata <= pwrite ? `UEM_ZERO32 : rd_nxt;
	end

endmodule // uem_bank

// >>> uem_map.vh
// Register map and field constants of the uncorrectable error suppress bank.
// Included by every design file of the bank; definitions only.
`ifndef UEM_MAP_VH
`define UEM_MAP_VH

// Register byte offsets within the port's configuration space
`define UEM_OFF_STS 12'h104
`define UEM_OFF_SUP 12'h108
`define UEM_OFF_FEP 12'h118
`define UEM_OFF_HDR0 12'h11c
`define UEM_OFF_HDR1 12'h120
`define UEM_OFF_HDR2 12'h124
`define UEM_OFF_HDR3 12'h128
`define UEM_OFF_IEN 12'h130

// Error event bit positions
`define UEM_B_TRAIN 0
`define UEM_B_DLPE 4
`define UEM_B_POIS 12
`define UEM_B_FCPE 13
`define UEM_B_CTO 14
`define UEM_B_CABT 15
`define UEM_B_UCPL 16
`define UEM_B_ROVF 17
`define UEM_B_MALF 18
`define UEM_B_ECRC 19
`define UEM_B_UREQ 20
`define UEM_B_ACSV 21

// Reset values and field widths
`define UEM_SUP_RST 1'b0
`define UEM_STS_RST 1'b0
`define UEM_IEN_RST 1'b0
`define UEM_ZERO32 32'h0000_0000
`define UEM_FEP_RST 5'h00
`define UEM_FEP_W 5
`define UEM_HDR_DW 4
`define UEM_HDR_LAST 2'h3

`endif

// >>> uem_err_slice.v
// One error bit of the bank: sticky suppress bit, sticky status bit, irq enable.
// Assumes a single clock; hot_rst is a synchronous non-power-on reset.
`timescale 1ns/100ps
`include "uem_map.vh"

module uem_err_slice (
	// Clock and resets
	input wire pclk,
	input wire presetn,
	input wire hot_rst,
	// Error event
	input wire evt,
	// Register writes
	input wire sup_we,
	input wire sup_d,
	input wire sts_w1c,
	input wire ien_we,
	input wire ien_d,
	// State and gated event
	output reg sup_r,
	output reg sts_r,
	output reg ien_r,
	output wire fwd
);

	reg sts_nxt;

	// Event passes to logging and messaging only while not suppressed
	assign fwd = evt & ~sup_r;

	always @* begin
		sts_nxt = sts_r;
		if (sts_w1c)
			sts_nxt = 1'b0;
		if (evt)
			sts_nxt = 1'b1;
	end

	// Suppress and status bits survive hot reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sup_r <= `UEM_SUP_RST;
			sts_r <= `UEM_STS_RST;
		end else begin
			if (sup_we)
				sup_r <= sup_d;
			sts_r <= sts_nxt;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ien_r <= `UEM_IEN_RST;
		else if (hot_rst)
			ien_r <= `UEM_IEN_RST;
		else if (ien_we)
			ien_r <= ien_d;
	end

endmodule // uem_err_slice

// >>> uem_bank_asserts.sv
// Port-level checks of the uncorrectable error suppress bank.
// Assumes one pclk domain, presetn low as reset.
`timescale 1ns/100ps
module uem_bank_asserts (
	// Clock and resets
	input logic pclk,
	input logic presetn,
	input logic hot_rst,
	// APB
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic pready,
	input logic pslverr,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic [3:0] pstrb,
	// Events and outputs
	input logic [31:0] err_evt,
	input logic [31:0] msg_vec,
	input logic [127:0] err_hdr,
	input logic log_pulse,
	input logic msg_pulse,
	input logic irq
);
	localparam logic [31:0] RSV = 32'hffc0_0fee;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	rsv_msg_a: assert property ((msg_vec & RSV) == 0)
		else $error("msg_vec on unsupported bit");
	msg_cause_a: assert property ((msg_vec & ~$past(err_evt)) == 0)
		else $error("msg_vec without event");
	pulse_vec_a: assert property (msg_pulse == (msg_vec != 0))
		else $error("msg_pulse and msg_vec disagree");
	log_msg_a: assert property (log_pulse |-> msg_pulse)
		else $error("suppressed event logged");
	hot_clear_a: assert property (hot_rst |=> !msg_pulse && !log_pulse)
		else $error("pulse after hot reset");
	rd_rsv_a: assert property (psel && penable && !pwrite && paddr == 12'h108
		|-> (prdata & RSV) == 0)
		else $error("reserved suppress bit reads one");
	hdr_map_a: assert property (psel && penable && paddr >= 12'h11c && paddr <= 12'h128
		|-> !pslverr && pready)
		else $error("header log dword unmapped");
	irq_cause_a: assert property ($rose(irq)
		|-> $past(|err_evt) || $past(psel && penable && pwrite))
		else $error("irq rose without cause");
	cover property (log_pulse);
	cover property (msg_pulse && !log_pulse);
	cover property (pslverr);
endmodule // uem_bank_asserts

bind uem_bank uem_bank_asserts i_uem_bank_asserts (.pclk(pclk), .presetn(presetn),
	.hot_rst(hot_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
	.pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pstrb(pstrb),
	.err_evt(err_evt), .msg_vec(msg_vec), .err_hdr(err_hdr), .log_pulse(log_pulse),
	.msg_pulse(msg_pulse), .irq(irq));

// >>> testbench.sv
// Self-checking bench of the suppress bank: APB master, event driver, model.
// Assumes a zero-wait APB slave and one-cycle event pulses.
`timescale 1ns/100ps
module testbench;
	localparam logic [31:0] M = 32'h003f_f011;
	logic pclk = 0, presetn = 0, hot_rst = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, err_evt = 0, prdata, msg_vec, q, h, sup, ev, ex;
	logic [127:0] err_hdr = 0;
	logic pready, pslverr, log_pulse, msg_pulse, irq, e;
	logic [31:0] seed = 32'd3552;
	int n_errors = 0, total_checks = 0;
	// Reference model of the bank, kept from the rules alone
	logic [31:0] m_sup = 0, m_sts = 0, m_ien = 0, m_hdr = 0, m_vec = 0;
	int m_fep = 0;
	bit m_full = 0, m_log = 0;
	logic [31:0] m_msgq[$];
	always #2.5 pclk = ~pclk;
	uem_bank i_uem_bank (.pclk(pclk), .presetn(presetn), .hot_rst(hot_rst), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .err_evt(err_evt),
		.err_hdr(err_hdr), .log_pulse(log_pulse), .msg_pulse(msg_pulse),
		.msg_vec(msg_vec), .irq(irq));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("checks=%0d mismatches=%0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// One APB transfer; q and e take read data and error at the pready edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1) begin
			n_errors++;
			conclude();
		end
		q = prdata;
		e = pslverr;
		if (w && a == 12'h104) m_sts &= ~(d & M);
		if (w && a == 12'h108) m_sup = d & M;
		if (w && a == 12'h130) m_ien = d & M;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Event pulse for one cycle; outputs are settled on return
	task automatic fire(input logic [31:0] v);
		logic [127:0] hd;
		hd = {rnd(), rnd(), rnd(), rnd()};
		m_vec = v & M & ~m_sup;
		if (m_full && !m_sts[m_fep]) m_full = 0;
		m_sts |= v & M;
		m_log = (m_vec != 0) && !m_full;
		if (m_log) begin
			m_full = 1;
			m_hdr = hd[31:0];
			for (int b = 31; b >= 0; b--)
				if (m_vec[b]) m_fep = b;
		end
		m_msgq.push_back(m_vec);
		err_evt <= v;
		err_hdr <= hd;
		@(posedge pclk);
		err_evt <= 32'h0;
		#1;
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 12'h108, 0);
		chk(q, 32'h0);
		apb(1, 12'h108, 32'hffff_ffff);
		apb(0, 12'h108, 0);
		chk(q, M);
		hot_rst <= 1'b1;
		m_ien = 0;
		@(posedge pclk);
		hot_rst <= 1'b0;
		apb(0, 12'h108, 0);
		chk(q, M);
		apb(0, 12'h200, 0);
		chk({31'h0, e}, 32'h1);
		$display("test map_sticky done");
		apb(1, 12'h130, M);
		apb(0, 12'h130, 0);
		chk(q, m_ien);
		for (int i = 0; i < 24; i++) begin
			sup = rnd();
			ev = rnd();
			apb(1, 12'h108, sup);
			apb(0, 12'h108, 0);
			chk(q, m_sup);
			fire(ev);
			ex = m_msgq.pop_front();
			chk(msg_vec, ex);
			chk({31'h0, msg_pulse}, {31'h0, |m_vec});
			chk({31'h0, log_pulse}, {31'h0, m_log});
			chk({31'h0, irq}, {31'h0, |(m_sts & m_ien)});
			@(posedge pclk);
			apb(0, 12'h104, 0);
			chk(q, m_sts);
			apb(1, 12'h104, 32'hffff_ffff);
			chk({31'h0, irq}, {31'h0, |(m_sts & m_ien)});
		end
		$display("test random_suppress done");
		apb(1, 12'h108, 0);
		fire(32'h4000);
		h = err_hdr[31:0];
		chk(msg_vec, m_msgq.pop_front());
		chk({31'h0, log_pulse}, {31'h0, m_log});
		@(posedge pclk);
		fire(32'h8000);
		chk({31'h0, log_pulse}, 32'h0);
		chk(msg_vec, m_msgq.pop_front());
		@(posedge pclk);
		apb(0, 12'h118, 0);
		chk(q & 32'h1f, 32'he);
		chk(q & 32'h1f, m_fep);
		apb(0, 12'h11c, 0);
		chk(q, h);
		chk(q, m_hdr);
		$display("test header_log done");
		conclude();
	end
endmodule // testbench
